// ---- rtl/isl_pkg.sv ----
// constants, types and state layout of the bus slave interface
// Contract
// - ready released once data valid or latched
// - pull 16-bit select low on range match
// - 16-bit I/O only after select seen high
// - grounded 16-bit select forces 8-bit I/O
// - 16-bit select decodes address and enable only
// - I/O read needs enable low and match
// - I/O write needs enable low and match
// - interrupt request when any status flag set; here only unmasked flags raise it
// - per-flag mask gates request, flag still records
// - straps pick base 300/320/340/360, compare address
// - shared match is memory access, strobe gives direction
// - 8-bit only until byte-high enable falls
package isl_pkg;
    localparam int ADDR_W = 10;                 // system address bits 0..9
    localparam int DATA_W = 16;                 // system data width
    localparam int NUM_FLAGS = 6;               // interrupt status flags
    localparam int IO_WIN_BITS = 5;             // 32-byte window, low bits pick offset
    localparam int SYNC_W = 8 + 2 + ADDR_W + DATA_W; // pins through synchroniser
    localparam logic [ADDR_W-1:0] IO_BASE_0 = 10'h300; // base for straps 00
    localparam int BASE_STEP_SHIFT = 5;         // each strap step adds 20 hex
    // flag positions
    localparam int BABBLE_ERROR_FLAG = 0;
    localparam int MISSED_FRAME_FLAG = 1;
    localparam int MEMORY_ERROR_FLAG = 2;
    localparam int RECEIVE_DONE_FLAG = 3;
    localparam int INIT_DONE_FLAG = 4;
    localparam int TRANSMIT_STARTED_FLAG = 5;
    localparam logic BYTE_HIGH_RST = 1'b1;      // pin idles high on pull-up

    // access sequencer states, one-hot
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_BUSY = 3'b010,
        ST_DONE = 3'b100
    } isl_state_t;

    // whole state of the slave
    typedef struct packed {
        isl_state_t           st;
        logic [NUM_FLAGS-1:0] flags;
        logic [DATA_W-1:0]    rdData;
        logic [DATA_W-1:0]    wrData;
        logic [ADDR_W-1:0]    addr;
        logic                 isWrite;
        logic                 isMem;
        logic                 isWide;
        logic                 seenCs16High;
        logic                 seenByteHighFall;
        logic                 byteHighPrev;
    } isl_regs_t;
endpackage

// ---- rtl/isl_sync.sv ----
// two-flop synchroniser for a vector of pin inputs
`timescale 1ns/1ps
module isl_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input  wire logic             mclk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] meta_q; // first stage, read only by second

    // plain two-stage capture; bits are not coherent with each other
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            meta_q <= RST_VAL;
            dout   <= RST_VAL;
        end else begin
            meta_q <= din;
            dout   <= meta_q;
        end
    end
endmodule

// ---- rtl/isl_slave.sv ----
// bus slave: decode, width control, pacing, data bus and interrupt request
`timescale 1ns/1ps
module isl_slave (
    input  wire logic                          mclk,
    input  wire logic                          rst,
    input  wire logic                          addrEnable,
    input  wire logic                          ioRdN,
    input  wire logic                          ioWrN,
    input  wire logic                          memRdN,
    input  wire logic                          memWrN,
    input  wire logic                          sharedMemMatch,
    input  wire logic                          byteHighEnN,
    input  wire logic [1:0]                    ioBaseSelectStraps,
    input  wire logic [isl_pkg::ADDR_W-1:0]    sysAddr,
    input  wire logic [isl_pkg::DATA_W-1:0]    sysDataIn,
    output logic      [isl_pkg::DATA_W-1:0]    sysDataOut,
    output logic                               sysDataOeN,
    input  wire logic                          cs16In,
    output logic                               cs16Out,
    output logic                               cs16OeN,
    output logic                               chanRdyOut,
    output logic                               chanRdyOeN,
    output logic                               irqReq,
    input  wire logic [isl_pkg::NUM_FLAGS-1:0] flagEvent,
    input  wire logic [isl_pkg::NUM_FLAGS-1:0] flagClear,
    input  wire logic [isl_pkg::NUM_FLAGS-1:0] flagMask,
    output logic      [isl_pkg::NUM_FLAGS-1:0] flagStatus,
    output logic                               reqValid,
    output logic                               reqWrite,
    output logic                               reqMem,
    output logic                               reqWide,
    output logic      [isl_pkg::ADDR_W-1:0]    reqAddr,
    output logic      [isl_pkg::DATA_W-1:0]    reqWrData,
    input  wire logic                          reqAck,
    input  wire logic [isl_pkg::DATA_W-1:0]    reqRdData,
    output logic                               wideEnabled
);
    import isl_pkg::*;

    // reset image of the state
    localparam isl_regs_t REGS_RST = '{st: ST_IDLE, byteHighPrev: BYTE_HIGH_RST, default: '0};
    // idle levels of synchronised pins: strobes, enable and byte-high high;
    // select read-back and shared match start low, so that the reset image is never
    // taken as proof of a wired select line, nor as a memory match
    localparam logic [SYNC_W-1:0] SYNC_RST = {6'h3f, 1'b0, 1'b0, 2'h0, {ADDR_W{1'b0}}, {DATA_W{1'b0}}};

    isl_regs_t r_q;                  // registered state
    isl_regs_t r_d;                  // next state
    logic [SYNC_W-1:0] pinsS;        // synchronised pin bundle
    logic aenS;                      // address enable after sync
    logic ioRdS;                     // read strobe, active low
    logic ioWrS;                     // write strobe, active low
    logic memRdS;                    // memory read strobe, active low
    logic memWrS;                    // memory write strobe, active low
    logic byteHighS;                 // byte-high enable, active low
    logic cs16S;                     // sampled 16-bit select line
    logic smMatchS;                  // shared memory match
    logic [1:0] strapS;              // base select straps
    logic [ADDR_W-1:0] addrS;        // system address
    logic [DATA_W-1:0] dataS;        // system data
    logic [ADDR_W-1:0] ioBase;       // selected base address
    logic ioMatch;                   // pure address/enable decode
    logic ioRdHit;                   // qualified slave read
    logic ioWrHit;                   // qualified slave write
    logic memRdHit;                  // shared memory read
    logic memWrHit;                  // shared memory write
    logic anyStrobe;                 // any strobe still asserted

    // every pin passes two flops; straps are sampled continuously so jumpers may move
    isl_sync #(
        .WIDTH   (SYNC_W),
        .RST_VAL (SYNC_RST)
    ) u_sync (
        .mclk (mclk),
        .rst  (rst),
        .din  ({addrEnable, ioRdN, ioWrN, memRdN, memWrN, byteHighEnN, cs16In, sharedMemMatch,
                ioBaseSelectStraps, sysAddr, sysDataIn}),
        .dout (pinsS)
    );

    // unpack the bundle
    assign {aenS, ioRdS, ioWrS, memRdS, memWrS, byteHighS, cs16S, smMatchS, strapS, addrS, dataS} = pinsS;

    // base from straps; upper address bits compared, low bits select offset
    assign ioBase   = IO_BASE_0 | (ADDR_W'(strapS) << BASE_STEP_SHIFT);
    assign ioMatch  = !aenS && (addrS[ADDR_W-1:IO_WIN_BITS] == ioBase[ADDR_W-1:IO_WIN_BITS]);
    assign ioRdHit  = ioMatch && !ioRdS;
    assign ioWrHit  = ioMatch && !ioWrS;
    assign memRdHit = smMatchS && !memRdS;
    assign memWrHit = smMatchS && !memWrS;
    assign anyStrobe = !ioRdS || !ioWrS || !memRdS || !memWrS;

    // next-state logic
    always_comb begin
        r_d = r_q;
        // hardware set beats software clear
        r_d.flags = (r_q.flags & ~flagClear) | flagEvent;
        // sticky proof that the 16-bit select line is really wired
        if (cs16S) begin
            r_d.seenCs16High = 1'b1;
        end
        // sticky proof of a 16-bit capable host
        r_d.byteHighPrev = byteHighS;
        if (r_q.byteHighPrev && !byteHighS) begin
            r_d.seenByteHighFall = 1'b1;
        end
        case (r_q.st)
            ST_IDLE: begin
                // io wins over memory if both appear; a real host never does both
                if (ioRdHit || ioWrHit) begin
                    r_d.st      = ST_BUSY;
                    r_d.isMem   = 1'b0;
                    r_d.isWrite = ioWrHit;
                    r_d.isWide  = wideEnabled && !byteHighS;
                    r_d.addr    = addrS;
                    r_d.wrData  = dataS;
                end else if (memRdHit || memWrHit) begin
                    r_d.st      = ST_BUSY;
                    r_d.isMem   = 1'b1;
                    r_d.isWrite = memWrHit;
                    r_d.isWide  = wideEnabled && !byteHighS;
                    r_d.addr    = addrS;
                    r_d.wrData  = dataS;
                end
            end
            ST_BUSY: begin
                // core answers; read data captured here so the bus sees a flop
                if (reqAck) begin
                    r_d.st = ST_DONE;
                    if (!r_q.isWrite) begin
                        r_d.rdData = reqRdData;
                    end
                end
            end
            ST_DONE: begin
                // hold data until the host lets go of its strobe
                if (!anyStrobe) begin
                    r_d.st = ST_IDLE;
                end
            end
            default: begin
                r_d.st = ST_IDLE;
            end
        endcase
    end

    // single state register
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            r_q <= REGS_RST;
        end else begin
            r_q <= r_d;
        end
    end

    // 16-bit allowed only once both proofs are in; grounded select never proves
    assign wideEnabled = r_q.seenCs16High && r_q.seenByteHighFall;
    // open-drain select: pure decode, no strobe term, and no low unless wide ok
    assign cs16Out = 1'b0;
    assign cs16OeN = !(ioMatch && wideEnabled);
    // open-drain ready: pulled low only while the core is still working
    assign chanRdyOut = 1'b0;
    assign chanRdyOeN = (r_q.st != ST_BUSY);
    // data bus only for a read that has its data
    assign sysDataOut = r_q.rdData;
    assign sysDataOeN = !((r_q.st == ST_DONE) && !r_q.isWrite);
    // core request
    assign reqValid   = (r_q.st == ST_BUSY);
    assign reqWrite   = r_q.isWrite;
    assign reqMem     = r_q.isMem;
    assign reqWide    = r_q.isWide;
    assign reqAddr    = r_q.addr;
    assign reqWrData  = r_q.wrData;
    // interrupt request from unmasked flags
    assign flagStatus = r_q.flags;
    assign irqReq     = |(r_q.flags & ~flagMask);

    // checks
    AST_READY_AFTER_DATA: assert property (@(posedge mclk) disable iff (rst)
        $rose(chanRdyOeN) |-> (r_q.st == ST_DONE) && (r_q.isWrite || !sysDataOeN))
        else $error("ready released before data valid");
    AST_CS16_DECODE: assert property (@(posedge mclk) disable iff (rst)
        (ioMatch && wideEnabled) |-> !cs16OeN)
        else $error("16-bit select not driven on match");
    AST_CS16_NEEDS_PROOF: assert property (@(posedge mclk) disable iff (rst)
        !cs16OeN |-> r_q.seenCs16High && r_q.seenByteHighFall && ioMatch)
        else $error("16-bit select driven without proof");
    // select may only move with address, enable, straps or width proof, never with a strobe
    AST_CS16_STROBE_FREE: assert property (@(posedge mclk) disable iff (rst)
        ($stable(aenS) && $stable(addrS) && $stable(strapS) && $stable(wideEnabled)) |-> $stable(cs16OeN))
        else $error("16-bit select depends on a strobe");
    AST_NARROW_WHEN_GROUNDED: assert property (@(posedge mclk) disable iff (rst)
        (reqValid && !r_q.seenCs16High) |-> !reqWide)
        else $error("wide access with grounded select");
    AST_READ_QUALIFIED: assert property (@(posedge mclk) disable iff (rst)
        ($rose(reqValid) && !reqWrite && !reqMem) |-> !$past(aenS) && $past(ioMatch) && !$past(ioRdS))
        else $error("read accepted without qualification");
    AST_WRITE_QUALIFIED: assert property (@(posedge mclk) disable iff (rst)
        ($rose(reqValid) && reqWrite && !reqMem) |-> !$past(aenS) && $past(ioMatch) && !$past(ioWrS))
        else $error("write accepted without qualification");
    AST_IRQ_ON_FLAG: assert property (@(posedge mclk) disable iff (rst)
        (flagEvent[RECEIVE_DONE_FLAG] && !flagMask[RECEIVE_DONE_FLAG]) ##1
        !flagMask[RECEIVE_DONE_FLAG] |-> irqReq)
        else $error("unmasked flag gave no interrupt");
    AST_MASK_RECORDS: assert property (@(posedge mclk) disable iff (rst)
        flagEvent[BABBLE_ERROR_FLAG] |=> flagStatus[BABBLE_ERROR_FLAG])
        else $error("flag event lost");
    AST_NARROW_BEFORE_FALL: assert property (@(posedge mclk) disable iff (rst)
        !r_q.seenByteHighFall |-> cs16OeN && !(reqValid && reqWide))
        else $error("16-bit before byte-high fall");
    AST_READY_IDLE_UNDRIVEN: assert property (@(posedge mclk) disable iff (rst)
        (r_q.st == ST_IDLE) |-> chanRdyOeN ##1 (r_q.st != ST_BUSY || !chanRdyOeN))
        else $error("ready driven outside access");
    AST_DATA_ONLY_READ: assert property (@(posedge mclk) disable iff (rst)
        !sysDataOeN |-> (r_q.st == ST_DONE) && !r_q.isWrite)
        else $error("data bus driven outside read");

    COV_IO_READ: cover property (@(posedge mclk) disable iff (rst)
        $rose(reqValid) && !reqWrite && !reqMem ##[1:20] !sysDataOeN);
    COV_IO_WRITE: cover property (@(posedge mclk) disable iff (rst)
        $rose(reqValid) && reqWrite && !reqMem);
    COV_MEM_ACCESS: cover property (@(posedge mclk) disable iff (rst)
        $rose(reqValid) && reqMem);
    COV_WIDE: cover property (@(posedge mclk) disable iff (rst)
        reqValid && reqWide);
endmodule

// ---- verif/isl_host_model.sv ----
// host bus model: strobes, address and data toward the slave, open-drain lines read back
`timescale 1ns/1ps
module isl_host_model (
    input  wire logic        mclk,
    input  wire logic        cs16Gnd,
    input  wire logic        cs16OeN,
    input  wire logic        chanRdyOeN,
    input  wire logic        sysDataOeN,
    input  wire logic [15:0] sysDataOut,
    output logic             addrEnable,
    output logic             ioRdN,
    output logic             ioWrN,
    output logic             memRdN,
    output logic             memWrN,
    output logic             sharedMemMatch,
    output logic             byteHighEnN,
    output logic [9:0]       sysAddr,
    output logic [15:0]      sysDataIn,
    output logic             cs16In
);
    logic [15:0] hostData = 16'h0000; // write data put on the bus
    logic        hostDrive = 1'b0;    // host drives data only during writes
    logic [15:0] lastData = 16'h0000; // wire value one cycle back
    // pull-up on the select wire; a grounded strap holds it low for good
    assign cs16In = ~cs16Gnd & cs16OeN;
    // undriven data wire flips every cycle, so a stale value never looks valid
    assign sysDataIn = !sysDataOeN ? sysDataOut : (hostDrive ? hostData : ~lastData);
    always @(posedge mclk) lastData <= sysDataIn;
    // bus idles with every strobe released and enable high
    initial begin
        {ioRdN, ioWrN, memRdN, memWrN} = 4'hf;
        addrEnable = 1'b1;
        sharedMemMatch = 1'b0;
        byteHighEnN = 1'b1;
        sysAddr = 10'h000;
    end
    // one strobe cycle: k 0 io read, 1 io write, 2 mem read, 3 mem write
    task automatic bus_cycle(input int k, input logic aen, input logic [9:0] a, input logic [15:0] d,
                             output logic [15:0] rd, output logic held, output logic drv);
        int n;
        @(negedge mclk);
        sysAddr = a;
        addrEnable = aen;
        sharedMemMatch = k > 1;
        hostData = d;
        hostDrive = k[0];
        ioRdN = k != 0;
        ioWrN = k != 1;
        memRdN = k != 2;
        memWrN = k != 3;
        n = 0;
        // a slave that never pulls ready low is taken as not selected
        do begin @(posedge mclk); #1; n++; end while (chanRdyOeN && n < 8);
        held = !chanRdyOeN;
        n = 0;
        while (held && !chanRdyOeN && n < 40) begin @(posedge mclk); #1; n++; end
        rd = sysDataOut;
        drv = !sysDataOeN;
        @(negedge mclk);
        {ioRdN, ioWrN, memRdN, memWrN} = 4'hf;
        addrEnable = 1'b1;
        sharedMemMatch = 1'b0;
        hostDrive = 1'b0;
        // slave must see the release through its synchroniser before the next cycle
        repeat (5) @(negedge mclk);
    endtask
endmodule

// ---- verif/tb_top.sv ----
// self-checking bench: io decode, width control, flags and shared memory path
`timescale 1ns/1ps
module tb_top;
    import isl_pkg::*;
    logic mclk = 1'b0, rst = 1'b1, cs16Gnd = 1'b0, reqAck = 1'b0;
    logic addrEnable, ioRdN, ioWrN, memRdN, memWrN, sharedMemMatch, byteHighEnN, cs16In;
    logic [1:0] ioBaseSelectStraps = 2'h0;
    logic [ADDR_W-1:0] sysAddr, reqAddr, sAddr;
    logic [DATA_W-1:0] sysDataIn, sysDataOut, reqWrData, reqRdData = 16'h0000, rd, sData;
    logic [NUM_FLAGS-1:0] flagEvent = 6'h00, flagClear = 6'h00, flagMask = 6'h00, flagStatus;
    logic sysDataOeN, cs16Out, cs16OeN, chanRdyOut, chanRdyOeN, irqReq, reqValid, reqWrite;
    logic reqMem, reqWide, wideEnabled, held, drv, sWrite, sMem, sWide;
    int miscompares = 0, checked = 0;
    isl_slave dut_u (.mclk, .rst, .addrEnable, .ioRdN, .ioWrN, .memRdN, .memWrN, .sharedMemMatch,
        .byteHighEnN, .ioBaseSelectStraps, .sysAddr, .sysDataIn, .sysDataOut, .sysDataOeN, .cs16In,
        .cs16Out, .cs16OeN, .chanRdyOut, .chanRdyOeN, .irqReq, .flagEvent, .flagClear, .flagMask,
        .flagStatus, .reqValid, .reqWrite, .reqMem, .reqWide, .reqAddr, .reqWrData, .reqAck,
        .reqRdData, .wideEnabled);
    isl_host_model host_u (.mclk, .cs16Gnd, .cs16OeN, .chanRdyOeN, .sysDataOeN, .sysDataOut,
        .addrEnable, .ioRdN, .ioWrN, .memRdN, .memWrN, .sharedMemMatch, .byteHighEnN, .sysAddr,
        .sysDataIn, .cs16In);
    always #25 mclk = ~mclk;
    // core side: one-cycle ack, data follows the window offset; request captured for checks
    always @(negedge mclk) begin
        reqAck <= reqValid && !reqAck;
        reqRdData <= {11'h000, reqAddr[4:0]} ^ 16'h5a3c;
        if (reqValid) begin
            {sWrite, sMem, sWide, sAddr, sData} <= {reqWrite, reqMem, reqWide, reqAddr, reqWrData};
        end
    end
    function automatic logic [15:0] rdexp(input logic [9:0] a);
        return {11'h000, a[4:0]} ^ 16'h5a3c;
    endfunction
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic cyc(input int k, input logic aen, input logic [9:0] a, input logic [15:0] d);
        host_u.bus_cycle(k, aen, a, d, rd, held, drv);
    endtask
    task automatic do_reset;
        rst = 1'b1;
        repeat (5) @(negedge mclk);
        rst = 0;
        repeat (2) @(negedge mclk);
    endtask
    task automatic test_reset;
        check("data enable", sysDataOeN, 16'h1);
        check("ready enable", chanRdyOeN, 16'h1);
        check("select enable", cs16OeN, 16'h1);
        check("select value", cs16Out, 16'h0);
        check("ready value", chanRdyOut, 16'h0);
        check("irq", irqReq, 16'h0);
        check("wide before fall", wideEnabled, 16'h0);
        $display("test reset done");
    endtask
    task automatic test_decode;
        logic [9:0] a;
        for (int s = 0; s < 4; s++) begin
            ioBaseSelectStraps = s[1:0];
            a = 10'h300 + 10'(s * 32 + s + 3);
            cyc(1, 1'b0, a, 16'hc0de ^ 16'(s));
            check("write held", held, 16'h1);
            check("write kind", {sMem, sWrite}, 16'h1);
            check("write offset", sAddr[4:0], a[4:0]);
            check("write data", sData, 16'hc0de ^ 16'(s));
            check("write drive", drv, 16'h0);
            cyc(0, 1'b0, a, 16'h0000);
            check("read data", rd, rdexp(a));
            check("read drive", drv, 16'h1);
            cyc(0, 1'b1, a, 16'h0000);
            check("aen high held", {held, drv}, 16'h0);
            cyc(1, 1'b0, a ^ 10'h020, 16'h1234);
            check("other base held", held, 16'h0);
        end
        $display("test decode done");
    endtask
    task automatic test_width;
        cs16Gnd = 1'b1;
        ioBaseSelectStraps = 2'h0;
        do_reset;
        host_u.byteHighEnN = 1'b0;
        cyc(1, 1'b0, 10'h302, 16'hbeef);
        check("grounded width", {sWide, wideEnabled}, 16'h0);
        cyc(1, 1'b0, 10'h303, 16'h00be);
        check("split high byte", {held, sWide, sAddr[4:0]}, 16'h43);
        cs16Gnd = 1'b0;
        repeat (4) @(negedge mclk);
        check("wide enable", wideEnabled, 16'h1);
        host_u.sysAddr = 10'h304;
        host_u.addrEnable = 1'b0;
        repeat (4) @(negedge mclk);
        check("decoded select", cs16OeN, 16'h0);
        host_u.addrEnable = 1'b1;
        repeat (4) @(negedge mclk);
        check("no enable select", cs16OeN, 16'h1);
        cyc(1, 1'b0, 10'h306, 16'h0102);
        check("wide access", sWide, 16'h1);
        $display("test width done");
    endtask
    task automatic test_flags;
        for (int i = 0; i < NUM_FLAGS; i++) begin
            flagEvent = 6'(1 << i);
            @(negedge mclk);
            flagEvent = 6'h00;
            @(negedge mclk);
            check("flag set", flagStatus, 16'(1 << i));
            check("irq set", irqReq, 16'h1);
            flagMask = 6'(1 << i);
            #1;
            check("masked irq", irqReq, 16'h0);
            check("masked flag", flagStatus, 16'(1 << i));
            flagClear = 6'(1 << i);
            @(negedge mclk);
            flagClear = 6'h00;
            flagMask = 6'h00;
            @(negedge mclk);
            check("cleared irq", irqReq, 16'h0);
        end
        flagEvent = 6'h01;
        flagClear = 6'h01;
        @(negedge mclk);
        flagEvent = 6'h00;
        flagClear = 6'h00;
        check("set beats clear", flagStatus, 16'h1);
        check("set beats clear irq", irqReq, 16'h1);
        flagClear = 6'h01;
        @(negedge mclk);
        flagClear = 6'h00;
        check("flag cleared", flagStatus, 16'h0);
        $display("test flags done");
    endtask
    task automatic test_mem;
        cyc(2, 1'b0, 10'h011, 16'h0000);
        check("mem read kind", {held, sMem, sWrite}, 16'h6);
        check("mem read data", rd, rdexp(10'h011));
        cyc(3, 1'b0, 10'h01a, 16'h7e81);
        check("mem write kind", {held, sMem, sWrite}, 16'h7);
        check("mem write data", sData, 16'h7e81);
        $display("test memory done");
    endtask
    task automatic wrap_up;
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        do_reset;
        test_reset;
        test_decode;
        test_flags;
        test_mem;
        test_width;
        wrap_up;
    end
    // watchdog: the tests need well under a thousand cycles
    initial begin
        #(5000 * 50);
        miscompares++;
        wrap_up;
    end
endmodule
